// [rps_pkg.sv]
// constants and types shared by the ram playback sequencer files
package rps_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int RAM_ADDR_W = 10;
    localparam int RAM_DATA_W = 32;
    localparam int RATE_W = 16;
    localparam int MODE_W = 3;
    localparam int INTERP_W = 6;
    localparam int TMR_W = 24;
    localparam int APB_ADDR_W = 8;
    localparam int APB_DATA_W = 32;
    localparam int TMR_BASE_MULT = 4;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SEG0_ADDR = 8'h00;
    localparam logic [7:0] OFS_SEG0_CFG = 8'h04;
    localparam logic [7:0] OFS_SEG1_ADDR = 8'h08;
    localparam logic [7:0] OFS_SEG1_CFG = 8'h0C;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_COMMIT = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_RAM_PTR = 8'h1C;
    localparam logic [7:0] OFS_RAM_DATA = 8'h20;
    localparam logic [7:0] SEG_STRIDE = 8'h08;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SA_LSB = 0;
    localparam int EA_LSB = 16;
    localparam int RATE_LSB = 0;
    localparam int MODE_LSB = 16;
    localparam int DEST_BIT = 0;
    localparam int INTERP_LSB = 8;
    localparam int ST_ADDR_LSB = 0;
    localparam int ST_STATE_LSB = 16;
    localparam int ST_SEL_BIT = 20;
    localparam int ST_RT_BIT = 24;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] SEG_ADDR_RST = 32'h0000_0000;
    localparam logic [31:0] SEG_CFG_RST = 32'h0000_0001;
    localparam logic [31:0] CTRL_RST = 32'h0000_0100;

    // ------------------------------------------------------------
    // playback mode codes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_RAMP_UP = 3'h1;
    localparam logic [2:0] MODE_BIDIR = 3'h2;
    localparam logic [2:0] MODE_CONT_BIDIR = 3'h3;
    localparam logic [2:0] MODE_RECIRC = 3'h4;

    typedef enum logic [1:0] {ST_HALT, ST_ARMED, ST_UP, ST_DOWN} rps_state_t;

endpackage

// [rps_tmr_if.sv]
// interface between the sequencer and its playback timer
interface rps_tmr_if;
    import rps_pkg::*;
    logic restart;
    logic run;
    logic [TMR_W-1:0] interval;
    logic expire;

    modport seq (output restart, output run, output interval, input expire);
    modport tmr (input restart, input run, input interval, output expire);
endinterface

// [rps_timer.sv]
// playback timer that paces the address steps
module rps_timer (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // sequencer side
    rps_tmr_if.tmr bus
);
    import rps_pkg::*;

    logic [TMR_W-1:0] cnt;
    logic [TMR_W-1:0] next_cnt;
    logic at_end;

    // ------------------------------------------------------------
    // count
    // ------------------------------------------------------------
    // compare with >= so that a shortened interval never strands the count
    assign at_end = (cnt >= bus.interval - TMR_W'(1));
    assign bus.expire = bus.run && !bus.restart && at_end;

    always_comb begin
        next_cnt = cnt + TMR_W'(1);
        if (bus.restart || !bus.run || bus.expire) begin
            next_cnt = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

endmodule

// [rps_sequencer.sv]
// ram playback address sequencer with apb registers and playback ram
//
// The APB slave port and the register addresses were left to the implementer.
import rps_pkg::*;

module rps_sequencer (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rps_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [rps_pkg::APB_DATA_W-1:0] pwdata,
    output logic [rps_pkg::APB_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // trigger pin
    input wire logic ram_trigger_pin,
    // playback destination
    output logic [rps_pkg::RAM_ADDR_W-1:0] pb_addr,
    output logic [rps_pkg::RAM_DATA_W-1:0] pb_data,
    output logic pb_strobe,
    output logic pb_running,
    output logic pb_to_scaler
);
    import rps_pkg::*;

    localparam int RAM_DEPTH = 1 << RAM_ADDR_W;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    rps_tmr_if tmr_bus ();

    logic wr_en;
    logic setup_rd;
    logic access;
    logic mapped;
    logic commit;
    logic [31:0] rd_word;
    logic [31:0] next_prdata;

    logic [31:0] seg_addr [2];
    logic [31:0] seg_cfg [2];
    logic [31:0] act_addr [2];
    logic [31:0] act_cfg [2];
    logic [31:0] cfg_addr [2];
    logic [31:0] cfg_cfg [2];
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic [31:0] act_ctrl;
    logic [31:0] next_act_ctrl;

    logic [RAM_DATA_W-1:0] ram [RAM_DEPTH];
    logic [RAM_ADDR_W-1:0] ram_ptr;
    logic [RAM_ADDR_W-1:0] next_ram_ptr;
    logic ram_wr;

    logic rt_q;
    logic rise;
    logic fall;

    rps_state_t state;
    rps_state_t next_state;
    logic [RAM_ADDR_W-1:0] addr;
    logic [RAM_ADDR_W-1:0] next_addr;
    logic sel;
    logic next_sel;
    logic next_strobe;
    logic restart;

    logic [RAM_ADDR_W-1:0] cur_start;
    logic [RAM_ADDR_W-1:0] cur_end;
    logic [MODE_W-1:0] cur_mode;
    logic [RATE_W-1:0] cur_rate;
    logic [INTERP_W-1:0] cur_interp;

    // ------------------------------------------------------------
    // field helpers
    // ------------------------------------------------------------
    function automatic logic [RAM_ADDR_W-1:0] start_of(input logic [31:0] w);
        return w[SA_LSB +: RAM_ADDR_W];
    endfunction

    function automatic logic [RAM_ADDR_W-1:0] end_of(input logic [31:0] w);
        return w[EA_LSB +: RAM_ADDR_W];
    endfunction

    function automatic logic [MODE_W-1:0] mode_of(input logic [31:0] w);
        return w[MODE_LSB +: MODE_W];
    endfunction

    function automatic logic valid_mode(input logic [MODE_W-1:0] m);
        logic ok;
        ok = 1'b0;
        unique case (m)
            MODE_RAMP_UP, MODE_BIDIR, MODE_CONT_BIDIR, MODE_RECIRC: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign access = psel && penable;
    assign wr_en = access && pwrite;
    assign setup_rd = psel && !penable && !pwrite;
    assign commit = wr_en && (paddr == OFS_COMMIT);
    assign ram_wr = wr_en && (paddr == OFS_RAM_DATA);

    always_comb begin
        unique case (paddr)
            OFS_SEG0_ADDR, OFS_SEG0_CFG, OFS_SEG1_ADDR, OFS_SEG1_CFG, OFS_CTRL,
            OFS_COMMIT, OFS_STATUS, OFS_RAM_PTR, OFS_RAM_DATA: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // status is read only, so a write there is flagged as well
    assign pslverr = access && (!mapped || (pwrite && paddr == OFS_STATUS));

    // ------------------------------------------------------------
    // segment registers, shadow and committed copies
    // ------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_seg
        logic [31:0] next_seg_addr;
        logic [31:0] next_seg_cfg;
        logic [31:0] next_act_addr;
        logic [31:0] next_act_cfg;
        localparam logic [7:0] OFS_A = OFS_SEG0_ADDR + 8'(i) * SEG_STRIDE;
        localparam logic [7:0] OFS_C = OFS_SEG0_CFG + 8'(i) * SEG_STRIDE;

        always_comb begin
            next_seg_addr = seg_addr[i];
            next_seg_cfg = seg_cfg[i];
            if (wr_en && paddr == OFS_A) begin
                next_seg_addr = '0;
                next_seg_addr[SA_LSB +: RAM_ADDR_W] = pwdata[SA_LSB +: RAM_ADDR_W];
                next_seg_addr[EA_LSB +: RAM_ADDR_W] = pwdata[EA_LSB +: RAM_ADDR_W];
            end
            if (wr_en && paddr == OFS_C) begin
                next_seg_cfg = '0;
                next_seg_cfg[RATE_LSB +: RATE_W] = pwdata[RATE_LSB +: RATE_W];
                next_seg_cfg[MODE_LSB +: MODE_W] = pwdata[MODE_LSB +: MODE_W];
            end
            // settings only take hold on a commit strobe
            next_act_addr = commit ? seg_addr[i] : act_addr[i];
            next_act_cfg = commit ? seg_cfg[i] : act_cfg[i];
            cfg_addr[i] = next_act_addr;
            cfg_cfg[i] = next_act_cfg;
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                seg_addr[i] <= SEG_ADDR_RST;
                seg_cfg[i] <= SEG_CFG_RST;
                act_addr[i] <= SEG_ADDR_RST;
                act_cfg[i] <= SEG_CFG_RST;
            end else begin
                seg_addr[i] <= next_seg_addr;
                seg_cfg[i] <= next_seg_cfg;
                act_addr[i] <= next_act_addr;
                act_cfg[i] <= next_act_cfg;
            end
        end
    end

    // ------------------------------------------------------------
    // control register and ram pointer
    // ------------------------------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        next_act_ctrl = commit ? ctrl : act_ctrl;
        next_ram_ptr = ram_ptr;
        if (wr_en && paddr == OFS_CTRL) begin
            next_ctrl = '0;
            next_ctrl[DEST_BIT] = pwdata[DEST_BIT];
            next_ctrl[INTERP_LSB +: INTERP_W] = pwdata[INTERP_LSB +: INTERP_W];
        end
        if (wr_en && paddr == OFS_RAM_PTR) begin
            next_ram_ptr = pwdata[RAM_ADDR_W-1:0];
        end else if (access && paddr == OFS_RAM_DATA) begin
            // reads and writes of the data port walk through the ram
            next_ram_ptr = ram_ptr + RAM_ADDR_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RST;
            act_ctrl <= CTRL_RST;
            ram_ptr <= '0;
        end else begin
            ctrl <= next_ctrl;
            act_ctrl <= next_act_ctrl;
            ram_ptr <= next_ram_ptr;
        end
    end

    // memory has no reset; contents are undefined until loaded
    always_ff @(posedge pclk) begin
        if (ram_wr) begin
            ram[ram_ptr] <= pwdata;
        end
    end

    // ------------------------------------------------------------
    // read data, captured in the setup cycle
    // ------------------------------------------------------------
    always_comb begin
        rd_word = '0;
        unique case (paddr)
            OFS_SEG0_ADDR: rd_word = seg_addr[0];
            OFS_SEG0_CFG: rd_word = seg_cfg[0];
            OFS_SEG1_ADDR: rd_word = seg_addr[1];
            OFS_SEG1_CFG: rd_word = seg_cfg[1];
            OFS_CTRL: rd_word = ctrl;
            OFS_RAM_PTR: rd_word[RAM_ADDR_W-1:0] = ram_ptr;
            OFS_RAM_DATA: rd_word = ram[ram_ptr];
            OFS_STATUS: begin
                rd_word[ST_ADDR_LSB +: RAM_ADDR_W] = addr;
                rd_word[ST_STATE_LSB +: 2] = state;
                rd_word[ST_SEL_BIT] = sel;
                rd_word[ST_RT_BIT] = rt_q;
            end
            default: rd_word = '0;
        endcase
        next_prdata = setup_rd ? rd_word : prdata;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else begin
            prdata <= next_prdata;
        end
    end

    // ------------------------------------------------------------
    // trigger pin edges
    // ------------------------------------------------------------
    // the pin is synchronous to pclk, so one flop suffices for edges
    assign rise = ram_trigger_pin && !rt_q;
    assign fall = !ram_trigger_pin && rt_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rt_q <= 1'b0;
        end else begin
            rt_q <= ram_trigger_pin;
        end
    end

    // ------------------------------------------------------------
    // playback timer
    // ------------------------------------------------------------
    assign cur_start = start_of(act_addr[sel]);
    assign cur_end = end_of(act_addr[sel]);
    assign cur_mode = mode_of(act_cfg[sel]);
    // zero rate or factor is read as one so the timer never stalls
    assign cur_rate = (act_cfg[sel][RATE_LSB +: RATE_W] == '0) ? RATE_W'(1)
                      : act_cfg[sel][RATE_LSB +: RATE_W];
    assign cur_interp = (act_ctrl[INTERP_LSB +: INTERP_W] == '0) ? INTERP_W'(1)
                        : act_ctrl[INTERP_LSB +: INTERP_W];

    always_comb begin
        tmr_bus.interval = TMR_W'(TMR_BASE_MULT) * TMR_W'(cur_interp);
        if (act_ctrl[DEST_BIT]) begin
            tmr_bus.interval = TMR_W'(TMR_BASE_MULT) * TMR_W'(cur_interp)
                               * TMR_W'(cur_rate);
        end
    end

    assign tmr_bus.run = (state == ST_UP) || (state == ST_DOWN);
    assign tmr_bus.restart = restart;

    rps_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .bus(tmr_bus.tmr)
    );

    // ------------------------------------------------------------
    // address sequencer
    // ------------------------------------------------------------
    always_comb begin
        logic esel;
        logic [MODE_W-1:0] emode;
        esel = fall;
        emode = mode_of(cfg_cfg[fall]);
        next_state = state;
        next_addr = addr;
        next_sel = sel;
        next_strobe = 1'b0;
        restart = 1'b0;
        if (rise || fall) begin
            // a pin edge wins over a commit in the same cycle, using the new settings
            restart = 1'b1;
            next_sel = esel;
            next_strobe = 1'b1;
            unique case (emode)
                MODE_BIDIR: begin
                    if (rise) begin
                        next_addr = start_of(cfg_addr[0]);
                        next_state = ST_UP;
                    end else begin
                        next_addr = end_of(cfg_addr[1]);
                        next_state = ST_DOWN;
                    end
                end
                MODE_RAMP_UP, MODE_CONT_BIDIR, MODE_RECIRC: begin
                    next_addr = start_of(cfg_addr[esel]);
                    next_state = ST_UP;
                end
                default: begin
                    next_state = ST_HALT;
                    next_strobe = 1'b0;
                end
            endcase
        end else if (commit) begin
            restart = 1'b1;
            unique case (mode_of(cfg_cfg[sel]))
                MODE_BIDIR: begin
                    next_sel = 1'b0;
                    next_state = ST_ARMED;
                end
                MODE_RAMP_UP, MODE_CONT_BIDIR, MODE_RECIRC: begin
                    next_addr = start_of(cfg_addr[sel]);
                    next_state = ST_UP;
                    next_strobe = 1'b1;
                end
                default: next_state = ST_HALT;
            endcase
        end else if (tmr_bus.expire) begin
            next_strobe = 1'b1;
            if (state == ST_UP) begin
                if (addr != cur_end) begin
                    next_addr = addr + RAM_ADDR_W'(1);
                end else if (cur_mode == MODE_CONT_BIDIR) begin
                    next_addr = addr - RAM_ADDR_W'(1);
                    next_state = ST_DOWN;
                end else if (cur_mode == MODE_RECIRC) begin
                    next_addr = cur_start;
                end else begin
                    next_state = ST_HALT;
                    next_strobe = 1'b0;
                end
            end else begin
                if (addr != cur_start) begin
                    next_addr = addr - RAM_ADDR_W'(1);
                end else if (cur_mode == MODE_CONT_BIDIR) begin
                    next_addr = addr + RAM_ADDR_W'(1);
                    next_state = ST_UP;
                end else begin
                    next_state = ST_HALT;
                    next_strobe = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_HALT;
            addr <= '0;
            sel <= 1'b0;
            pb_strobe <= 1'b0;
        end else begin
            state <= next_state;
            addr <= next_addr;
            sel <= next_sel;
            pb_strobe <= next_strobe;
        end
    end

    // ------------------------------------------------------------
    // playback outputs
    // ------------------------------------------------------------
    // the word is refreshed every cycle, so a halted address keeps presenting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pb_addr <= '0;
            pb_data <= '0;
        end else begin
            pb_addr <= addr;
            pb_data <= ram[addr];
        end
    end

    assign pb_running = tmr_bus.run;
    assign pb_to_scaler = act_ctrl[DEST_BIT];

endmodule

// [rps_assertions.sv]
// concurrent checks on the playback sequencer ports
module rps_chk (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rps_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [rps_pkg::APB_DATA_W-1:0] pwdata,
    input wire logic [rps_pkg::APB_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // trigger and playback
    input wire logic ram_trigger_pin,
    input wire logic [rps_pkg::RAM_ADDR_W-1:0] pb_addr,
    input wire logic [rps_pkg::RAM_DATA_W-1:0] pb_data,
    input wire logic pb_strobe,
    input wire logic pb_running,
    input wire logic pb_to_scaler
);
    timeunit 1ns;
    timeprecision 1ps;
    import rps_pkg::*;
    wire cmt = psel && penable && pwrite && paddr == OFS_COMMIT;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // no trigger acts at this edge
    sequence s_q;
        !$changed(ram_trigger_pin) && !cmt;
    endsequence
    a_addr_hold: assert property (!pb_strobe |=> $stable(pb_addr))
        else $error("address moved without a strobe");
    a_step_gap: assert property (pb_strobe ##0 s_q |=> !pb_strobe)
        else $error("two steps in a row");
    a_gap_three: assert property (pb_strobe ##0 s_q[*3] |=> !pb_strobe)
        else $error("timer period below four");
    a_halt_quiet: assert property (!pb_running ##0 s_q |=> !pb_strobe)
        else $error("step while halted");
    a_halt_keep: assert property ($fell(pb_running) |-> !pb_strobe)
        else $error("address changed on halt");
    a_dest_commit: assert property ($changed(pb_to_scaler) |-> $past(cmt))
        else $error("destination changed without commit");
    a_ready_high: assert property (psel && penable |-> pready)
        else $error("no ready");
    a_bad_addr: assert property (psel && penable && paddr > OFS_RAM_DATA |-> pslverr)
        else $error("no error on unmapped address");
    a_status_ro: assert property (psel && penable && pwrite && paddr == OFS_STATUS |-> pslverr)
        else $error("status write accepted");
endmodule
bind rps_sequencer rps_chk i_rps_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ram_trigger_pin, .pb_addr, .pb_data, .pb_strobe,
    .pb_running, .pb_to_scaler);

// [rps_trig_model.sv]
// external controller that drives the trigger pin
module rps_trig_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench requests
    input wire logic req,
    input wire logic lvl,
    // pin
    output logic ram_trigger_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // levels change just after an edge and last whole cycles, as a real controller would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_trigger_pin <= 1'b0;
        end else if (req) begin
            ram_trigger_pin <= lvl;
        end
    end
endmodule

// [testbench.sv]
// self-checking bench for the ram playback sequencer
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import rps_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic req = 1'b0, lvl = 1'b0, pready, pslverr, pin, pb_strobe, pb_running, pb_to_scaler, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, pb_data, rd;
    logic [9:0] pb_addr;
    logic [2:0] bad [4] = '{3'h0, 3'h5, 3'h6, 3'h7};
    int num_errors = 0, tests_run = 0, seed = 32'h1E5E, cyc = 0, last = 0;
    int s0, e0, s1, e1, r, m;
    always #5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    rps_sequencer i_rps_sequencer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .ram_trigger_pin(pin), .pb_addr, .pb_data,
        .pb_strobe, .pb_running, .pb_to_scaler);
    rps_trig_model i_rps_trig_model (.pclk, .presetn, .req, .lvl, .ram_trigger_pin(pin));
    // ----
    // helpers
    // ----
    function automatic logic [31:0] dat(input logic [9:0] a);
        return {6'h2A, a, 6'h15, ~a};
    endfunction
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic play(input logic [2:0] md, input int rt);
        apb(1'b1, OFS_SEG0_ADDR, {6'h0, 10'(e0), 6'h0, 10'(s0)});
        apb(1'b1, OFS_SEG0_CFG, {13'h0, md, 16'(rt)});
        apb(1'b1, OFS_SEG1_ADDR, {6'h0, 10'(e1), 6'h0, 10'(s1)});
        apb(1'b1, OFS_SEG1_CFG, {13'h0, md, 16'(rt)});
        apb(1'b1, OFS_COMMIT, 32'h0);
    endtask
    task automatic pin_to(input logic l);
        req <= 1'b1;
        lvl <= l;
        @(posedge pclk);
        req <= 1'b0;
    endtask
    // g of zero skips the spacing check, used for the first word after a trigger
    task automatic nxt(input int a, input int g);
        int n;
        n = 0;
        @(posedge pclk);
        while (pb_strobe !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        // a strobe that never came counts as a mismatch here
        `CHK("strobe", 1'b1, pb_strobe)
        if (g != 0) `CHK("gap", g, cyc - last)
        last = cyc;
        @(posedge pclk);
        `CHK("address", 10'(a), pb_addr)
        `CHK("data", dat(10'(a)), pb_data)
    endtask
    task automatic run(input int a, input int b, input int g, input int g0);
        for (int i = 0; i <= (a > b ? a - b : b - a); i++)
            nxt(a > b ? a - i : a + i, i == 0 ? g0 : g);
    endtask
    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge pclk);
            `CHK("idle strobe", 1'b0, pb_strobe)
        end
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_SEG0_CFG, 32'h0);
        `CHK("cfg reset", SEG_CFG_RST, rd)
        apb(1'b0, OFS_CTRL, 32'h0);
        `CHK("ctrl reset", CTRL_RST, rd)
        apb(1'b0, 8'h24, 32'h0);
        `CHK("unmapped", 33'h1_0000_0000, {er, rd})
        apb(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
        `CHK("status write", 1'b1, er)
        // bits outside the segment fields must read back as zero
        apb(1'b1, OFS_SEG1_ADDR, 32'hFFFF_FFFF);
        apb(1'b0, OFS_SEG1_ADDR, 32'h0);
        `CHK("seg addr fields", 32'h03FF_03FF, rd)
        apb(1'b1, OFS_SEG1_CFG, 32'hFFFF_FFFF);
        apb(1'b0, OFS_SEG1_CFG, 32'h0);
        `CHK("seg cfg fields", 32'h0007_FFFF, rd)
        apb(1'b1, OFS_RAM_PTR, 32'h0);
        // data keyed by address: words 0 to 63 are loaded in order, covering both segments
        for (int a = 0; a < 64; a++) apb(1'b1, OFS_RAM_DATA, dat(10'(a)));
        s0 = $unsigned($random(seed)) % 20;
        e0 = s0 + 2 + $unsigned($random(seed)) % 3;
        s1 = 32 + $unsigned($random(seed)) % 20;
        e1 = s1 + 3;
        play(MODE_RAMP_UP, 1);
        run(s0, e0, 4, 0);
        quiet(12);
        `CHK("halt address", 10'(e0), pb_addr)
        pin_to(1'b1);
        run(s0, e0, 4, 0);
        pin_to(1'b0);
        run(s1, e1, 4, 0);
        play(MODE_RECIRC, 1);
        run(s1, e1, 4, 0);
        run(s1, s1 + 1, 4, 4);
        pin_to(1'b1);
        run(s0, e0, 4, 0);
        play(MODE_CONT_BIDIR, 1);
        run(s0, e0, 4, 0);
        run(e0 - 1, s0, 4, 4);
        nxt(s0 + 1, 4);
        pin_to(1'b0);
        run(s1, e1, 4, 0);
        play(MODE_BIDIR, 1);
        quiet(10);
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK("armed", 2'h1, rd[17:16])
        pin_to(1'b1);
        run(s0, s0 + 1, 4, 0);
        pin_to(1'b0);
        run(e1, e1 - 1, 4, 0);
        run(e1 - 2, s1, 4, 4);
        quiet(12);
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK("bidir halt", 13'h1000 | 13'(s1), {rd[20], rd[17:16], rd[9:0]})
        foreach (bad[k]) begin
            // start a waveform first, so only the invalid commit can stop it
            play(MODE_RECIRC, 1);
            play(bad[k], 1);
            quiet(8);
            apb(1'b0, OFS_STATUS, 32'h0);
            `CHK("invalid", 2'h0, rd[17:16])
        end
        r = 1 + $unsigned($random(seed)) % 2;
        m = 1 + $unsigned($random(seed)) % 3;
        apb(1'b1, OFS_CTRL, (32'(r) << INTERP_LSB) | 32'h1);
        play(MODE_RAMP_UP, m);
        run(s1, e1, TMR_BASE_MULT * r * m, 0);
        `CHK("scaler", 1'b1, pb_to_scaler)
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        complete_run();
    end
endmodule
